// *** inc/rcwc_params.svh ***
`ifndef RCWC_PARAMS_SVH
`define RCWC_PARAMS_SVH

// Processor clocks from release of the clear input to the first fetch.
`define RCWC_FETCH_DELAY_CLKS 7
// Processor clocks for which the status lines are driven idle on entry to reset.
`define RCWC_STATUS_IDLE_CLKS 1
// Width and idle level of the bus status lines.
`define RCWC_STATUS_W 3
`define RCWC_STATUS_IDLE 3'h7
// Synchroniser bit positions.
`define RCWC_SYNC_W 3
`define RCWC_SYNC_CLEAR 0
`define RCWC_SYNC_TEST 1
`define RCWC_SYNC_OSC 2
// Reset values of the synchroniser flops: clear asserted, test low, oscillator low.
`define RCWC_SYNC_RESET 3'h0

`endif

// *** inc/rcwc_pkg.sv ***
package rcwc_pkg;

  // Gray along hold -> count -> run.
  typedef enum logic [1:0] {
    RS_HOLD = 2'h0,
    RS_COUNT = 2'h1,
    RS_RUN = 2'h3
  } rcwc_rst_state_type;

  typedef enum logic {
    WS_IDLE = 1'h0,
    WS_WAIT = 1'h1
  } rcwc_wait_state_type;

endpackage : rcwc_pkg

// *** inc/rcwc_sync_if.sv ***
`include "rcwc_params.svh"

interface rcwc_sync_if;
  logic [`RCWC_SYNC_W-1:0] async_in;
  logic [`RCWC_SYNC_W-1:0] sync_out;

  modport owner (
    output async_in,
    input sync_out
  );

  modport syncer (
    input async_in,
    output sync_out
  );
endinterface : rcwc_sync_if

// *** rtl/rcwc_sync.sv ***
`include "rcwc_params.svh"

module rcwc_sync #(
  parameter int WIDTH = `RCWC_SYNC_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins in, synchronised levels out
  rcwc_sync_if.syncer sif
);

  // Refused at elaboration: the bit positions of the pins are fixed.
  if (WIDTH != `RCWC_SYNC_W) begin : g_bad_width
    $error("rcwc_sync: WIDTH must match the synchroniser layout.");
  end

  localparam logic [WIDTH-1:0] SYNC_RESET = `RCWC_SYNC_RESET;

  // ****************************************************************
  // Two-flop synchroniser, one per pin.
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_reg;
      logic stable_reg;
      // The first flop is read only by the second.
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          meta_reg <= SYNC_RESET[gi];
          stable_reg <= SYNC_RESET[gi];
        end else begin
          meta_reg <= sif.async_in[gi];
          stable_reg <= meta_reg;
        end
      end
      assign sif.sync_out[gi] = stable_reg;
    end
  endgenerate

endmodule : rcwc_sync

// *** rtl/rcwc_top.sv ***
`include "rcwc_params.svh"

// Operation
// - Clear input low stops activity at once, clears logic, holds core dormant.
// - Clear input may be asynchronous; it is synchronised before use.
// - Fetching starts seven processor clocks after clear input returns high.
// - On reset entry, status lines driven idle one clock, then released.
// - Reset output is high, clock-aligned, whole clocks long, tracking clear input.
// - Processor clock is the oscillator input divided by two.
// - Divided clock goes out with 50 percent duty; it times reset output, fetch and idle counts, and test resampling.
// - Wait with test high suspends, resamples test, resumes once test low.
// - While suspended on test, enabled interrupts are still serviced.
// - Test input is synchronised before it is evaluated.
module rcwc_top
  import rcwc_pkg::*;
#(
  parameter int FETCH_DELAY = `RCWC_FETCH_DELAY_CLKS,
  parameter int STATUS_IDLE_CLKS = `RCWC_STATUS_IDLE_CLKS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Oscillator pins
  input wire logic oscillator_in_a,
  input wire logic oscillator_in_b,
  output logic divided_clock_out,
  // Reset pins
  input wire logic system_clear_in_n,
  output logic reset_out,
  // Core sequencing
  output logic core_dormant,
  output logic fetch_start,
  // Bus status pins
  input wire logic [`RCWC_STATUS_W-1:0] core_status,
  output logic [`RCWC_STATUS_W-1:0] status_out,
  output logic [`RCWC_STATUS_W-1:0] status_oe_n,
  // Wait on test pin
  input wire logic test_in,
  input wire logic wait_begin,
  output logic wait_stall,
  output logic wait_done,
  // Interrupts during wait
  input wire logic intr_enabled,
  input wire logic intr_pending,
  output logic intr_grant
);

  // Refused at elaboration: the counters are four and two bits wide.
  if (FETCH_DELAY < 1 || FETCH_DELAY > 15) begin : g_bad_fetch_delay
    $error("rcwc_top: FETCH_DELAY must lie in 1 to 15.");
  end
  if (STATUS_IDLE_CLKS < 1 || STATUS_IDLE_CLKS > 3) begin : g_bad_idle_clks
    $error("rcwc_top: STATUS_IDLE_CLKS must lie in 1 to 3.");
  end

  localparam logic [3:0] FETCH_LAST = 4'(FETCH_DELAY);
  localparam logic [1:0] IDLE_LAST = 2'(STATUS_IDLE_CLKS);
  localparam logic [`RCWC_STATUS_W-1:0] STATUS_IDLE = `RCWC_STATUS_IDLE;

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  rcwc_sync_if sif ();

  assign sif.async_in[`RCWC_SYNC_CLEAR] = system_clear_in_n;
  assign sif.async_in[`RCWC_SYNC_TEST] = test_in;
  assign sif.async_in[`RCWC_SYNC_OSC] = oscillator_in_a;

  rcwc_sync #(
    .WIDTH(`RCWC_SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .sif(sif)
  );

  wire clear_active = ~sif.sync_out[`RCWC_SYNC_CLEAR];
  wire test_high = sif.sync_out[`RCWC_SYNC_TEST];
  wire osc_level = sif.sync_out[`RCWC_SYNC_OSC];

  // ****************************************************************
  // Clock divider.
  // ****************************************************************
  // The second crystal pin only matters to the analogue oscillator; the
  // divider follows the first pin alone, so a floating second pin is harmless.
  logic osc_prev_reg;
  logic div_clk_reg;
  logic div_clk_next;

  wire osc_rise = osc_level & ~osc_prev_reg;
  // Every processor clock boundary is a rising edge of the divided clock.
  wire proc_tick = osc_rise & ~div_clk_reg;

  assign div_clk_next = osc_rise ? ~div_clk_reg : div_clk_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_prev_reg <= 1'h0;
      div_clk_reg <= 1'h0;
    end else begin
      osc_prev_reg <= osc_level;
      div_clk_reg <= div_clk_next;
    end
  end

  // Toggling on every oscillator rise gives equal high and low halves.
  assign divided_clock_out = div_clk_reg;

  // ****************************************************************
  // Reset sequencer.
  // ****************************************************************
  rcwc_rst_state_type rst_state_reg;
  rcwc_rst_state_type rst_state_next;
  logic [3:0] fetch_cnt_reg;
  logic [3:0] fetch_cnt_next;
  logic reset_out_reg;
  logic reset_out_next;
  logic dormant_reg;
  logic fetch_start_reg;

  wire fetch_due = proc_tick && (fetch_cnt_reg == FETCH_LAST - 4'h1);
  wire reset_entry = clear_active && (rst_state_reg != RS_HOLD);

  always_comb begin
    rst_state_next = rst_state_reg;
    fetch_cnt_next = fetch_cnt_reg;
    case (rst_state_reg)
      RS_HOLD: begin
        fetch_cnt_next = 4'h0;
        if (!clear_active) begin
          rst_state_next = RS_COUNT;
        end
      end
      RS_COUNT: begin
        if (fetch_due) begin
          rst_state_next = RS_RUN;
        end else if (proc_tick) begin
          fetch_cnt_next = fetch_cnt_reg + 4'h1;
        end
      end
      RS_RUN: begin
        fetch_cnt_next = 4'h0;
      end
      default: begin
        rst_state_next = RS_HOLD;
        fetch_cnt_next = 4'h0;
      end
    endcase
    // A clear in any state wins at once.
    if (clear_active) begin
      rst_state_next = RS_HOLD;
      fetch_cnt_next = 4'h0;
    end
  end

  // The reset output only moves on processor clock boundaries, so its
  // length is a whole number of processor clocks.
  assign reset_out_next = proc_tick ? clear_active : reset_out_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rst_state_reg <= RS_HOLD;
      fetch_cnt_reg <= 4'h0;
      reset_out_reg <= 1'h1;
      dormant_reg <= 1'h1;
      fetch_start_reg <= 1'h0;
    end else begin
      rst_state_reg <= rst_state_next;
      fetch_cnt_reg <= fetch_cnt_next;
      reset_out_reg <= reset_out_next;
      dormant_reg <= (rst_state_next != RS_RUN);
      fetch_start_reg <= (rst_state_reg == RS_COUNT) && fetch_due && !clear_active;
    end
  end

  assign reset_out = reset_out_reg;
  assign core_dormant = dormant_reg;
  assign fetch_start = fetch_start_reg;

  // ****************************************************************
  // Bus status lines.
  // ****************************************************************
  // The idle drive lasts from entry through STATUS_IDLE_CLKS whole processor
  // clocks; the partial clock in which reset arrives is not counted.
  logic idle_drive_reg;
  logic [1:0] idle_cnt_reg;
  logic [`RCWC_STATUS_W-1:0] status_out_reg;
  logic status_oe_n_reg;

  wire idle_done = proc_tick && (idle_cnt_reg == IDLE_LAST);
  wire drive_core = (rst_state_reg == RS_RUN) && !clear_active;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      idle_drive_reg <= 1'h0;
      idle_cnt_reg <= 2'h0;
    end else if (reset_entry) begin
      idle_drive_reg <= 1'h1;
      idle_cnt_reg <= 2'h0;
    end else if (idle_done) begin
      idle_drive_reg <= 1'h0;
      idle_cnt_reg <= 2'h0;
    end else if (idle_drive_reg && proc_tick) begin
      idle_cnt_reg <= idle_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_out_reg <= STATUS_IDLE;
      status_oe_n_reg <= 1'h1;
    end else if (reset_entry || (idle_drive_reg && !idle_done)) begin
      status_out_reg <= STATUS_IDLE;
      status_oe_n_reg <= 1'h0;
    end else if (drive_core) begin
      status_out_reg <= core_status;
      status_oe_n_reg <= 1'h0;
    end else begin
      status_out_reg <= STATUS_IDLE;
      status_oe_n_reg <= 1'h1;
    end
  end

  assign status_out = status_out_reg;
  assign status_oe_n = {`RCWC_STATUS_W{status_oe_n_reg}};

  // ****************************************************************
  // Wait on the test pin.
  // ****************************************************************
  rcwc_wait_state_type wait_state_reg;
  rcwc_wait_state_type wait_state_next;
  logic wait_done_reg;
  logic wait_done_next;

  wire running = (rst_state_reg == RS_RUN) && !clear_active;

  always_comb begin
    wait_state_next = wait_state_reg;
    wait_done_next = 1'h0;
    case (wait_state_reg)
      WS_IDLE: begin
        if (running && wait_begin) begin
          if (test_high) begin
            wait_state_next = WS_WAIT;
          end else begin
            wait_done_next = 1'h1;
          end
        end
      end
      WS_WAIT: begin
        // Test is resampled once per processor clock.
        if (proc_tick && !test_high) begin
          wait_state_next = WS_IDLE;
          wait_done_next = 1'h1;
        end
      end
      default: begin
        wait_state_next = WS_IDLE;
      end
    endcase
    if (!running) begin
      wait_state_next = WS_IDLE;
      wait_done_next = 1'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_state_reg <= WS_IDLE;
      wait_done_reg <= 1'h0;
    end else begin
      wait_state_reg <= wait_state_next;
      wait_done_reg <= wait_done_next;
    end
  end

  assign wait_stall = (wait_state_reg == WS_WAIT);
  assign wait_done = wait_done_reg;
  // The wait stays pending while the interrupt is taken, as on return the
  // core re-enters the same wait.
  assign intr_grant = wait_stall && running && intr_enabled && intr_pending;

endmodule : rcwc_top

// *** verification/rcwc_top_properties.sv ***
`include "rcwc_params.svh"

module rcwc_top_properties #(
  parameter int FETCH_DELAY = 7,
  parameter int STATUS_IDLE_CLKS = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins
  input wire logic oscillator_in_a,
  input wire logic oscillator_in_b,
  input wire logic divided_clock_out,
  input wire logic system_clear_in_n,
  input wire logic reset_out,
  input wire logic core_dormant,
  input wire logic fetch_start,
  input wire logic [`RCWC_STATUS_W-1:0] core_status,
  input wire logic [`RCWC_STATUS_W-1:0] status_out,
  input wire logic [`RCWC_STATUS_W-1:0] status_oe_n,
  input wire logic test_in,
  input wire logic wait_begin,
  input wire logic wait_stall,
  input wire logic wait_done,
  input wire logic intr_enabled,
  input wire logic intr_pending,
  input wire logic intr_grant
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_clear_dormant: assert property (!system_clear_in_n [*4] |-> core_dormant)
    else $error("clear low but core awake");
  a_fetch_wakes: assert property (fetch_start |-> !core_dormant && !reset_out)
    else $error("fetch while held");
  a_reset_tick: assert property ($changed(reset_out) |-> $rose(divided_clock_out))
    else $error("reset out off clock");
  a_reset_run: assert property (!core_dormant |-> !reset_out)
    else $error("reset out while running");
  a_idle_drive: assert property ($rose(core_dormant) |-> status_out == 3'h7 && status_oe_n == 3'h0)
    else $error("status not idle");
  a_idle_release: assert property (core_dormant && status_oe_n == 3'h0 |-> ##[1:60] status_oe_n == 3'h7)
    else $error("status not released");
  a_div_stable: assert property ($changed(divided_clock_out) |=> $stable(divided_clock_out) [*3])
    else $error("clock too fast");
  a_stall_cause: assert property ($rose(wait_stall) |-> $past(wait_begin) && !$past(core_dormant))
    else $error("stall without wait");
  a_done_pulse: assert property (wait_done |-> !wait_stall && ($past(wait_begin) || $past(wait_stall)))
    else $error("done without cause");
  a_grant_level: assert property (intr_grant |-> wait_stall && intr_enabled && intr_pending && !core_dormant)
    else $error("grant without cause");
  a_grant_given: assert property (wait_stall && intr_enabled && intr_pending &&
    $past(system_clear_in_n, 2) && $past(system_clear_in_n, 3) |-> intr_grant)
    else $error("grant missing");
  a_wait_reset: assert property (core_dormant |-> !wait_stall && !wait_done)
    else $error("wait kept in reset");
  a_test_hold: assert property ((test_in && system_clear_in_n) [*4] ##0 wait_stall |=> wait_stall)
    else $error("resumed with test high");
endmodule : rcwc_top_properties

bind rcwc_top rcwc_top_properties #(
  .FETCH_DELAY(FETCH_DELAY),
  .STATUS_IDLE_CLKS(STATUS_IDLE_CLKS)
) u_props (
  .sys_clk, .rst, .oscillator_in_a, .oscillator_in_b, .divided_clock_out, .system_clear_in_n,
  .reset_out, .core_dormant, .fetch_start, .core_status, .status_out, .status_oe_n, .test_in,
  .wait_begin, .wait_stall, .wait_done, .intr_enabled, .intr_pending, .intr_grant
);

// *** verification/rcwc_partner.sv ***
module rcwc_partner #(
  parameter int OSC_HALF_NS = 50,
  parameter int POWER_UP_NS = 50000,
  parameter int MIN_LOW_CLKS = 5
) (
  // Bench requests
  input wire logic clear_req,
  input wire logic test_req,
  input wire logic divided_clock_out,
  // Pins
  output logic oscillator_in_a,
  output logic oscillator_in_b,
  output logic system_clear_in_n,
  output logic test_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // The oscillator is offset from the system clock so its edges never share a time step.
  initial begin
    oscillator_in_a = 1'b0;
    #3;
    forever #(OSC_HALF_NS) oscillator_in_a = ~oscillator_in_a;
  end
  assign oscillator_in_b = ~oscillator_in_a;
  assign #2 test_in = test_req;
  initial begin
    system_clear_in_n = 1'b0;
    #(POWER_UP_NS);
    forever begin
      wait (!clear_req);
      #7 system_clear_in_n = 1'b1;
      wait (clear_req);
      #3 system_clear_in_n = 1'b0;
      repeat (MIN_LOW_CLKS) @(posedge divided_clock_out);
    end
  end
endmodule : rcwc_partner

// *** verification/reset_clock_wait_control_bench.sv ***
module reset_clock_wait_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OSC_HALF_NS = 50;
  localparam int FD = 7;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wait_begin = 1'b0;
  logic intr_enabled = 1'b0;
  logic intr_pending = 1'b0;
  logic clear_req = 1'b0;
  logic test_req = 1'b0;
  logic [2:0] core_status = 3'h0;
  logic oscillator_in_a, oscillator_in_b, divided_clock_out, system_clear_in_n, reset_out, core_dormant;
  logic fetch_start, test_in, wait_stall, wait_done, intr_grant, hi, en, pend;
  logic [2:0] status_out, status_oe_n;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'hf4eb;
  int i, n, k, h, l;

  rcwc_top #(.FETCH_DELAY(FD), .STATUS_IDLE_CLKS(1)) DUT (
    .sys_clk, .rst, .oscillator_in_a, .oscillator_in_b, .divided_clock_out, .system_clear_in_n,
    .reset_out, .core_dormant, .fetch_start, .core_status, .status_out, .status_oe_n, .test_in,
    .wait_begin, .wait_stall, .wait_done, .intr_enabled, .intr_pending, .intr_grant);
  rcwc_partner #(.OSC_HALF_NS(OSC_HALF_NS)) u_partner (.clear_req, .test_req, .divided_clock_out,
    .oscillator_in_a, .oscillator_in_b, .system_clear_in_n, .test_in);

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end

  function automatic logic fetch_ok(input int t);
    return t >= FD && t <= FD + 1;
  endfunction : fetch_ok

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Counts processor ticks from release of the clear pin to the fetch pulse.
  task automatic wait_fetch(output int t);
    logic prev;
    t = 0;
    @(posedge system_clear_in_n);
    prev = divided_clock_out;
    while (fetch_start !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      if (divided_clock_out && !prev) t++;
      prev = divided_clock_out;
    end
  endtask : wait_fetch

  task automatic half(output int c);
    logic v;
    v = divided_clock_out;
    c = 0;
    while (divided_clock_out === v) begin
      @(posedge sys_clk);
      #1;
      c++;
    end
  endtask : half

  task automatic start_wait();
    repeat (6) @(posedge sys_clk);
    wait_begin <= 1'b1;
    @(posedge sys_clk);
    wait_begin <= 1'b0;
    #1;
  endtask : start_wait

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("reset_out", 1'b1, reset_out);
    chk("dormant", 1'b1, core_dormant);
    wait_fetch(n);
    chk("fetch_ticks", 1'b1, fetch_ok(n));
    chk("reset_out", 1'b0, reset_out);
    @(posedge sys_clk);
    #1;
    chk("status_oe_n", 3'h0, status_oe_n);
    $display("test power_up done");
    half(h);
    half(h);
    half(l);
    chk("clk_phase_a", 8'(2 * OSC_HALF_NS / 10), 8'(h));
    chk("clk_phase_b", 8'(2 * OSC_HALF_NS / 10), 8'(l));
    $display("test clock done");
    for (i = 0; i < 24; i++) begin
      @(posedge sys_clk);
      {hi, en, pend} = 3'($random(seed));
      // Hand-written corners: a granted and a masked interrupt during a wait.
      if (i < 2) begin
        {hi, en, pend} = (i == 0) ? 3'h7 : 3'h5;
      end
      test_req <= hi;
      intr_enabled <= en;
      intr_pending <= pend;
      core_status <= 3'($random(seed));
      start_wait();
      chk("stall", hi, wait_stall);
      chk("done", !hi, wait_done);
      chk("grant", hi & en & pend, intr_grant);
      chk("status_fwd", core_status, status_out);
      if (hi) begin
        repeat (($random(seed) & 31) + 4) @(posedge sys_clk);
        #1;
        chk("stall_hold", 1'b1, wait_stall);
        @(posedge sys_clk);
        test_req <= 1'b0;
        for (k = 0; k < 60 && wait_done !== 1'b1; k++) begin
          @(posedge sys_clk);
          #1;
        end
        chk("resume", 1'b1, wait_done);
      end
    end
    $display("test wait done");
    @(posedge sys_clk);
    test_req <= 1'b1;
    start_wait();
    @(posedge sys_clk);
    clear_req <= 1'b1;
    for (k = 0; k < 10 && core_dormant !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("dormant", 1'b1, core_dormant);
    chk("stall_abandon", 1'b0, wait_stall);
    chk("idle_status", 3'h7, status_out);
    chk("idle_drive", 3'h0, status_oe_n);
    repeat (60) @(posedge sys_clk);
    test_req <= 1'b0;
    clear_req <= 1'b0;
    #1;
    chk("released", 3'h7, status_oe_n);
    chk("reset_out", 1'b1, reset_out);
    wait_fetch(n);
    chk("refetch_ticks", 1'b1, fetch_ok(n));
    chk("no_resume", 1'b0, wait_stall | wait_done);
    $display("test clear_in_wait done");
    complete_run();
  end
endmodule : reset_clock_wait_control_bench
